// >>> hdl/dmaab_ctrl.sv
// two-channel byte dma bus control: nmi abort/resume, external master, wait, reset
`timescale 1ns/1ps
`include "dmaab_defs.svh"

module dmaab_ctrl #(
	parameter logic [3:0] RESUME_CYCLES = 4'(`DMAAB_RESUME_CYCLES)
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [7:0] o_rd_data,
	input wire logic i_nmi_n,
	input wire logic i_external_wait_ready,
	input wire logic [1:0] i_transfer_request,
	input wire logic i_ext_master_bus_request_n,
	output logic o_ext_master_bus_grant_n,
	output logic o_bus_req,
	input wire logic i_bus_grant,
	input wire logic [7:0] i_bus_rdata,
	output dmaab_pkg::dmaab_bus_s o_bus,
	output logic [1:0] o_transfer_acknowledge_n,
	output logic o_port_address_latch_strobe,
	output logic o_terminal_count
);
	import dmaab_pkg::*;

	dmaab_state_s r_reg;
	dmaab_state_s r_next;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic f_memmem(input logic [5:0] mode);
		f_memmem = (mode[5:4] == `DMAAB_TYPE_MM);
	endfunction

	function automatic logic [7:0] f_step(input logic [7:0] v, input logic dec);
		f_step = dec ? 8'(v - 8'h01) : 8'(v + 8'h01);
	endfunction

	// the count register reads 01 on the last byte; 00 means a full 256
	function automatic logic f_last(input logic [7:0] count);
		f_last = (count == 8'h01);
	endfunction

	// ---------------------------------------------------------------
	// requests and arbitration terms
	// ---------------------------------------------------------------
	logic nmi_fall;
	logic wait_now;
	logic ext_req;
	logic ext_top;
	logic blocked;
	logic dma_want;
	logic ext_may;
	logic [1:0] req;
	logic [1:0] transfer_request_edge;
	logic [5:0] act_mode;
	logic dma_own;
	logic ext_own;
	logic resuming;

	// the edge detector reads only the second sync flop, never the first
	assign nmi_fall = r_reg.nmi_prev & ~r_reg.nmi_sync[1];
	assign wait_now = ~r_reg.rdy_sync[1];
	assign ext_req = r_reg.gcr[`DMAAB_GCR_EXT_EN] & ~r_reg.xreq_sync[1];
	assign ext_top = r_reg.gcr[`DMAAB_GCR_EXT_TOP];
	assign resuming = (r_reg.resume_cnt != 4'h0);
	assign blocked = r_reg.abort_flag | resuming;
	// a late nmi edge still allows the byte already committed
	assign dma_want = (|req) & (~blocked | r_reg.grace);
	// bottom priority waits for every pending or paused channel
	assign ext_may = ext_req & (ext_top | ~(|req));
	assign act_mode = r_reg.mode[r_reg.ch];
	assign dma_own = (r_reg.owner == DMAAB_OWN_DMA);
	assign ext_own = (r_reg.owner == DMAAB_OWN_EXT);

	always_comb begin
		req = 2'b00;
		transfer_request_edge = 2'b00;
		for (int c = 0; c < 2; c++) begin
			logic s;
			logic p;
			logic lvl;
			s = r_reg.transfer_request_sync[c][1];
			p = r_reg.mode[c][`DMAAB_MODE_POL];
			lvl = p ? s : ~s;
			transfer_request_edge[c] = p ? (~r_reg.transfer_request_prev[c] & s) : (r_reg.transfer_request_prev[c] & ~s);
			if (f_memmem(r_reg.mode[c])) begin
				req[c] = r_reg.en[c];
			end else if (r_reg.mode[c][`DMAAB_MODE_DEMAND]) begin
				req[c] = r_reg.en[c] & lvl;
			end else begin
				req[c] = r_reg.en[c] & r_reg.single_pend[c];
			end
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic c;
		logic [2:0] sub;
		logic blk;
		logic tc;
		r_next = r_reg;
		c = i_addr[3];
		sub = i_addr[2:0];
		blk = (i_addr[7:4] == 4'h0);
		tc = f_last(r_reg.cnt[r_reg.ch]);

		r_next.nmi_sync = {r_reg.nmi_sync[0], i_nmi_n};
		r_next.nmi_prev = r_reg.nmi_sync[1];
		r_next.rdy_sync = {r_reg.rdy_sync[0], i_external_wait_ready};
		r_next.xreq_sync = {r_reg.xreq_sync[0], i_ext_master_bus_request_n};
		for (int k = 0; k < 2; k++) begin
			r_next.transfer_request_sync[k] = {r_reg.transfer_request_sync[k][0], i_transfer_request[k]};
			r_next.transfer_request_prev[k] = r_reg.transfer_request_sync[k][1];
		end

		// one bus cycle plus three half clocks, rounded up to whole clocks
		if (resuming) begin
			r_next.resume_cnt = 4'(r_reg.resume_cnt - 4'h1);
		end

		unique case (r_reg.owner)
			DMAAB_OWN_IDLE: begin
				r_next.grace = 1'b0;
				if (i_bus_grant) begin
					if (ext_may) begin
						r_next.owner = DMAAB_OWN_EXT;
					end else if (dma_want) begin
						// channel 1 outranks channel 0, re-decided every byte
						r_next.owner = DMAAB_OWN_DMA;
						r_next.phase = DMAAB_PH_S1;
						r_next.ch = req[1];
						r_next.stop_pend = 1'b0;
					end
				end
			end
			DMAAB_OWN_EXT: begin
				// no byte boundary here: the external master lets go when it pleases
				if (!ext_req) begin
					r_next.owner = DMAAB_OWN_IDLE;
				end
			end
			DMAAB_OWN_DMA: begin
				unique case (r_reg.phase)
					DMAAB_PH_S1: begin
						r_next.phase = DMAAB_PH_S2;
					end
					DMAAB_PH_S2: begin
						// the source byte is captured as the read phase ends
						if (!(wait_now && f_memmem(act_mode))) begin
							r_next.phase = DMAAB_PH_S3;
							r_next.hold = i_bus_rdata;
						end
					end
					DMAAB_PH_S3: begin
						if (!wait_now) begin
							r_next.phase = DMAAB_PH_S4;
							r_next.stop_pend = r_reg.abort_flag;
						end
					end
					DMAAB_PH_S4: begin
						// byte boundary: always hand back, idle re-arbitrates
						r_next.owner = DMAAB_OWN_IDLE;
						r_next.grace = ~r_reg.stop_pend;
						r_next.cnt[r_reg.ch] = 8'(r_reg.cnt[r_reg.ch] - 8'h01);
						r_next.mem[r_reg.ch] = f_step(r_reg.mem[r_reg.ch],
							act_mode[`DMAAB_MODE_DEC]);
						if (f_memmem(act_mode)) begin
							r_next.port[r_reg.ch] = f_step(r_reg.port[r_reg.ch],
								act_mode[`DMAAB_MODE_DEC]);
						end
						r_next.single_pend[r_reg.ch] = 1'b0;
						if (tc) begin
							if (act_mode[`DMAAB_MODE_AUTO] && !f_memmem(act_mode)) begin
								r_next.port[r_reg.ch] = r_reg.bport[r_reg.ch];
								r_next.mem[r_reg.ch] = r_reg.bmem[r_reg.ch];
								r_next.cnt[r_reg.ch] = r_reg.bcnt[r_reg.ch];
							end else begin
								r_next.en[r_reg.ch] = 1'b0;
							end
						end
					end
				endcase
			end
			default: begin
				r_next.owner = DMAAB_OWN_IDLE;
			end
		endcase

		// requests on disabled channels are not remembered
		for (int k = 0; k < 2; k++) begin
			if (r_reg.en[k] && transfer_request_edge[k]) begin
				r_next.single_pend[k] = 1'b1;
			end
		end

		// ---------------------------------------------------------------
		// register writes
		// ---------------------------------------------------------------
		if (i_wr_stb) begin
			if (blk && sub == `DMAAB_OFS_CTRL) begin
				r_next.en[c] = i_wr_data[`DMAAB_CTRL_EN];
			end else if (blk && sub < `DMAAB_OFS_CTRL) begin
				// touching a channel register stops that channel
				r_next.en[c] = 1'b0;
				r_next.single_pend[c] = 1'b0;
				unique case (sub)
					`DMAAB_OFS_PORT: begin
						r_next.port[c] = i_wr_data;
						r_next.bport[c] = i_wr_data;
					end
					`DMAAB_OFS_MEM: begin
						r_next.mem[c] = i_wr_data;
						r_next.bmem[c] = i_wr_data;
					end
					`DMAAB_OFS_CNT: begin
						r_next.cnt[c] = i_wr_data;
						r_next.bcnt[c] = i_wr_data;
					end
					default: begin
						r_next.mode[c] = i_wr_data[5:0];
					end
				endcase
			end else if (i_addr == `DMAAB_OFS_GCR) begin
				r_next.gcr = i_wr_data;
			end else if (i_addr == `DMAAB_OFS_CLR && i_wr_data == `DMAAB_CLR_VALUE) begin
				r_next.abort_flag = 1'b0;
				r_next.resume_cnt = RESUME_CYCLES;
			end
		end

		// a new nmi edge beats a clear in the same cycle
		if (r_reg.gcr[`DMAAB_GCR_ABORT_EN] && nmi_fall) begin
			r_next.abort_flag = 1'b1;
		end

		// ---------------------------------------------------------------
		// register reads, data valid only in the following cycle
		// ---------------------------------------------------------------
		r_next.rdata = `DMAAB_RESET_VALUE;
		if (i_rd_stb) begin
			if (blk && sub <= `DMAAB_OFS_CTRL) begin
				unique case (sub)
					`DMAAB_OFS_PORT: r_next.rdata = r_reg.port[c];
					`DMAAB_OFS_MEM: r_next.rdata = r_reg.mem[c];
					`DMAAB_OFS_CNT: r_next.rdata = r_reg.cnt[c];
					`DMAAB_OFS_MODE: r_next.rdata = {2'b00, r_reg.mode[c]};
					default: r_next.rdata = 8'(r_reg.en[c]) << `DMAAB_CTRL_EN;
				endcase
			end else if (i_addr == `DMAAB_OFS_GCR) begin
				r_next.rdata = r_reg.gcr;
			end else if (i_addr == `DMAAB_OFS_STAT) begin
				r_next.rdata = {4'h0, ext_own, dma_own, resuming, r_reg.abort_flag};
			end
		end
	end

	// clearing the whole struct zeroes every register and drops ownership
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg <= '0;
		end else if (i_clk_en) begin
			r_reg <= r_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	logic phase_a;
	logic [1:0] ty;
	assign phase_a = (r_reg.phase == DMAAB_PH_S1) || (r_reg.phase == DMAAB_PH_S2);
	assign ty = act_mode[5:4];

	always_comb begin
		// only the read byte is held; addresses come from the live registers
		o_bus = '0;
		o_bus.wdata = r_reg.hold;
		if (dma_own) begin
			if (phase_a) begin
				o_bus.rd = 1'b1;
				o_bus.io = (ty == `DMAAB_TYPE_IO2M);
				o_bus.addr = (ty == `DMAAB_TYPE_M2IO) ? r_reg.mem[r_reg.ch] :
					r_reg.port[r_reg.ch];
			end else begin
				o_bus.wr = 1'b1;
				o_bus.io = (ty == `DMAAB_TYPE_M2IO);
				o_bus.addr = (ty == `DMAAB_TYPE_M2IO) ? r_reg.port[r_reg.ch] :
					r_reg.mem[r_reg.ch];
			end
		end
	end

	assign o_rd_data = r_reg.rdata;
	// held while owned, so the cpu never takes the bus back mid-byte
	assign o_bus_req = dma_own || ext_own || dma_want || ext_may;
	assign o_ext_master_bus_grant_n = ~ext_own;

	// ---------------------------------------------------------------
	// channel strobes
	// ---------------------------------------------------------------
	assign o_transfer_acknowledge_n[0] = ~(dma_own && !r_reg.ch);
	assign o_transfer_acknowledge_n[1] = ~(dma_own && r_reg.ch);
	// the port address goes out for any i/o type, hence the parked base address
	assign o_port_address_latch_strobe = dma_own && (r_reg.phase == DMAAB_PH_S1) &&
		!f_memmem(act_mode);
	assign o_terminal_count = dma_own && (r_reg.phase == DMAAB_PH_S4) &&
		f_last(r_reg.cnt[r_reg.ch]);
endmodule

// >>> hdl/dmaab_defs.svh
// register offsets, field positions and timing counts of the dma abort/wait controller
`ifndef DMAAB_DEFS_SVH
`define DMAAB_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define DMAAB_OFS_PORT 3'h0
`define DMAAB_OFS_MEM 3'h1
`define DMAAB_OFS_CNT 3'h2
`define DMAAB_OFS_MODE 3'h3
`define DMAAB_OFS_CTRL 3'h4
`define DMAAB_OFS_GCR 8'h10
`define DMAAB_OFS_STAT 8'h11
`define DMAAB_OFS_CLR 8'h13
`define DMAAB_CLR_VALUE 8'hF0
`define DMAAB_RESET_VALUE 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DMAAB_CTRL_EN 5
`define DMAAB_GCR_ABORT_EN 2
`define DMAAB_GCR_EXT_TOP 3
`define DMAAB_GCR_EXT_EN 4
`define DMAAB_MODE_AUTO 0
`define DMAAB_MODE_DEMAND 1
`define DMAAB_MODE_POL 2
`define DMAAB_MODE_DEC 3
`define DMAAB_TYPE_MM 2'h0
`define DMAAB_TYPE_M2IO 2'h1
`define DMAAB_TYPE_IO2M 2'h2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DMAAB_BUS_CYCLE_CLKS 4
`define DMAAB_RESUME_HALF_CLKS 3
`define DMAAB_RESUME_CYCLES (`DMAAB_BUS_CYCLE_CLKS + (`DMAAB_RESUME_HALF_CLKS + 1) / 2)

`endif

// >>> hdl/dmaab_pkg.sv
// types shared by the dma abort/wait controller
package dmaab_pkg;
	typedef enum logic [1:0] {
		DMAAB_OWN_IDLE = 2'b00,
		DMAAB_OWN_DMA = 2'b01,
		DMAAB_OWN_EXT = 2'b10
	} dmaab_owner_e;

	typedef enum logic [1:0] {
		DMAAB_PH_S1 = 2'b00,
		DMAAB_PH_S2 = 2'b01,
		DMAAB_PH_S3 = 2'b10,
		DMAAB_PH_S4 = 2'b11
	} dmaab_phase_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic io;
	} dmaab_bus_s;

	typedef struct packed {
		logic [1:0] nmi_sync;
		logic nmi_prev;
		logic [1:0] rdy_sync;
		logic [1:0] xreq_sync;
		logic [1:0][1:0] transfer_request_sync;
		logic [1:0] transfer_request_prev;
		logic [1:0][7:0] port;
		logic [1:0][7:0] mem;
		logic [1:0][7:0] cnt;
		logic [1:0][7:0] bport;
		logic [1:0][7:0] bmem;
		logic [1:0][7:0] bcnt;
		logic [1:0][5:0] mode;
		logic [1:0] en;
		logic [1:0] single_pend;
		logic [7:0] gcr;
		logic abort_flag;
		logic stop_pend;
		logic grace;
		logic [3:0] resume_cnt;
		dmaab_owner_e owner;
		dmaab_phase_e phase;
		logic ch;
		logic [7:0] hold;
		logic [7:0] rdata;
	} dmaab_state_s;
endpackage

// >>> verification/dmaab_checker.sv
// port assertions for the dma abort/wait controller
`timescale 1ns/1ps
module dmaab_checker #(
	parameter logic [3:0] RESUME_CYCLES = 4'h6
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_external_wait_ready,
	input wire logic i_ext_master_bus_request_n,
	input wire logic i_bus_grant,
	input wire logic o_bus_req,
	input wire dmaab_pkg::dmaab_bus_s o_bus,
	input wire logic [1:0] o_transfer_acknowledge_n,
	input wire logic o_ext_master_bus_grant_n,
	input wire logic o_port_address_latch_strobe,
	input wire logic o_terminal_count
);
	import dmaab_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ---------------------------------------------------------------
	// ownership and strobes
	// ---------------------------------------------------------------
	property p_rst_idle;
		$rose(i_rst_n) |-> o_transfer_acknowledge_n == 2'h3 && !o_bus_req;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("transfer alive after reset");
	property p_ack_one;
		o_transfer_acknowledge_n != 2'h0;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("two acknowledges at once");
	property p_ack_owned;
		o_transfer_acknowledge_n != 2'h3 |-> o_bus_req && i_bus_grant && o_ext_master_bus_grant_n;
	endproperty
	a_ack_owned: assert property (p_ack_owned) else $error("acknowledge without bus");
	property p_ext_cause;
		!o_ext_master_bus_grant_n |-> !($past(i_ext_master_bus_request_n, 2)
			&& $past(i_ext_master_bus_request_n, 3) && $past(i_ext_master_bus_request_n, 4));
	endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("external grant unasked");
	property p_latch;
		o_port_address_latch_strobe |-> o_bus.rd ##1 !o_port_address_latch_strobe;
	endproperty
	a_latch: assert property (p_latch) else $error("latch strobe outside first state");
	property p_tc;
		o_terminal_count |-> (o_bus.wr && o_transfer_acknowledge_n != 2'h3) ##1 !o_bus.wr;
	endproperty
	a_tc: assert property (p_tc) else $error("terminal count off the last state");
	// ---------------------------------------------------------------
	// wait and resume
	// ---------------------------------------------------------------
	// ready passes two sync flops, so the history reaches back that far
	property p_byte_len;
		$rose(o_bus.wr) && i_external_wait_ready && $past(i_external_wait_ready)
			&& $past(i_external_wait_ready, 2) |=> o_bus.wr ##1 !o_bus.wr;
	endproperty
	a_byte_len: assert property (p_byte_len) else $error("write phase stretched");
	property p_wait_hold;
		o_bus.wr && !i_external_wait_ready && !$past(i_external_wait_ready)
			&& !$past(i_external_wait_ready, 2) && !$past(i_external_wait_ready, 3)
			|=> o_bus.wr ##1 o_bus.wr;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait not honoured");
	property p_resume;
		i_wr_stb && i_addr == 8'h13 && i_wr_data == 8'hF0 && !o_bus_req
			&& i_ext_master_bus_request_n |=> !o_bus_req [*4];
	endproperty
	a_resume: assert property (p_resume) else $error("bus request back too early");
endmodule

// >>> verification/dmaab_cpu_model.sv
// cpu core model: hands the bus over on request and serves memory reads
`timescale 1ns/1ps
module dmaab_cpu_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_bus_req,
	input wire logic i_slow,
	input wire dmaab_pkg::dmaab_bus_s i_bus,
	output logic o_bus_grant,
	output logic [7:0] o_bus_rdata
);
	import dmaab_pkg::*;
	logic [2:0] dly;
	logic [7:0] churn;
	// slow mode finishes a few more instructions before letting go
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dly <= 3'h0;
			churn <= 8'h00;
			o_bus_grant <= 1'h0;
		end else begin
			dly <= {dly[1:0], i_bus_req};
			churn <= churn + 8'h5B;
			o_bus_grant <= i_bus_req && (!i_slow || dly[2]);
		end
	end
	// undriven data lines outside a read must not look like a stale byte
	assign o_bus_rdata = i_bus.rd ? ~i_bus.addr : churn;
endmodule

// >>> verification/dmaab_ctrl_tb_top.sv
// self-checking bench of the dma abort/wait controller
`timescale 1ns/1ps
module dmaab_ctrl_tb_top;
	import dmaab_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic nmi_n = 1'h1;
	logic rdy = 1'h1;
	logic [1:0] treq = 2'h0;
	logic xreq_n = 1'h1;
	logic slow = 1'h0;
	logic pw = 1'h0;
	logic ce = 1'h1;
	logic [7:0] rdat, brd, la, ld;
	logic xgnt_n, breq, bgnt, port_address_latch_strobe, tc;
	logic [1:0] ack_n, lk;
	dmaab_bus_s bus;
	int nb = 0;
	int n, k, r;
	int errors = 0;
	int checked = 0;
	always #2.5 clk = ~clk;
	dmaab_ctrl i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_addr(addr),
		.i_wr_data(wd), .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdat), .i_nmi_n(nmi_n),
		.i_external_wait_ready(rdy), .i_transfer_request(treq),
		.i_ext_master_bus_request_n(xreq_n), .o_ext_master_bus_grant_n(xgnt_n),
		.o_bus_req(breq), .i_bus_grant(bgnt), .i_bus_rdata(brd), .o_bus(bus),
		.o_transfer_acknowledge_n(ack_n), .o_port_address_latch_strobe(port_address_latch_strobe),
		.o_terminal_count(tc));
	dmaab_cpu_model i_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_bus_req(breq), .i_slow(slow),
		.i_bus(bus), .o_bus_grant(bgnt), .o_bus_rdata(brd));
	// ---------------------------------------------------------------
	// byte monitor and bus tasks
	// ---------------------------------------------------------------
	// sampled mid-cycle, where the combinational bus has settled
	always @(negedge clk) begin
		pw <= bus.wr;
		if (bus.wr && !pw) begin
			nb++;
			la <= bus.addr;
			ld <= bus.wdata;
			lk <= ack_n;
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(rdat, e);
	endtask
	task automatic cfg(input logic [7:0] b, p, m, c, md);
		w(b, p);
		w(b | 8'h01, m);
		w(b | 8'h02, c);
		w(b | 8'h03, md);
		w(b | 8'h04, 8'h20);
	endtask
	task automatic wack;
		for (k = 0; k < 100 && ack_n === 2'h3; k++) @(negedge clk);
		chk(ack_n !== 2'h3, 8'h01);
	endtask
	task automatic wtc;
		for (k = 0; k < 300 && tc !== 1'h1; k++) @(negedge clk);
		chk(tc, 8'h01);
		repeat (3) @(negedge clk);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] a[13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B,
			8'h0C, 8'h10, 8'h11, 8'h1F};
		foreach (a[i]) rc(a[i], 8'h00);
		chk({xgnt_n, breq, ack_n}, 8'h0B);
		// a write while the clock enable is low must not land
		@(posedge clk);
		ce <= 1'h0;
		w(8'h10, 8'h1C);
		ce <= 1'h1;
		rc(8'h10, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_mm;
		slow <= 1'h1;
		n = nb;
		cfg(8'h00, 8'h20, 8'h40, 8'h02, 8'h00);
		wtc;
		chk(8'(nb - n), 8'h02);
		chk(la, 8'h41);
		chk(ld, 8'hDE);
		chk(lk, 8'h02);
		rc(8'h04, 8'h00);
		rc(8'h01, 8'h42);
		slow <= 1'h0;
		$display("memory copy test done");
	endtask
	task automatic pulse;
		@(posedge clk);
		nmi_n <= 1'h0;
		repeat (4) @(posedge clk);
		nmi_n <= 1'h1;
	endtask
	task automatic t_abort;
		w(8'h10, 8'h04);
		pulse;
		rc(8'h11, 8'h01);
		w(8'h13, 8'h0F);
		rc(8'h11, 8'h01);
		w(8'h13, 8'hF0);
		repeat (12) @(posedge clk);
		rc(8'h11, 8'h00);
		n = nb;
		cfg(8'h00, 8'h20, 8'h40, 8'h08, 8'h00);
		for (r = 0; r < 2; r++) begin
			wack;
			pulse;
			repeat (20) @(posedge clk);
			rc(8'h11, 8'h01);
			rc(8'h02, 8'(8 - (nb - n)));
			w(8'h13, 8'hF0);
			for (k = 0; k < 20 && breq !== 1'h1; k++) @(negedge clk);
			chk(k > 3 && k < 9, 8'h01);
		end
		wtc;
		chk(8'(nb - n), 8'h08);
		$display("abort test done");
	endtask
	task automatic t_wait(input logic [7:0] b, input logic [7:0] md, input logic [1:0] e);
		@(posedge clk);
		rdy <= 1'h0;
		treq <= 2'h3;
		cfg(b, 8'h30, 8'h60, 8'h01, md);
		wack;
		chk(port_address_latch_strobe, 8'(md[5:4] != 2'h0));
		repeat (12) @(negedge clk);
		chk({bus.rd, bus.wr}, e);
		@(posedge clk);
		rdy <= 1'h1;
		wtc;
		chk(ld, 8'hCF);
		chk(lk, b[3] ? 8'h01 : 8'h02);
		treq <= 2'h0;
		$display("wait test done");
	endtask
	task automatic t_nmi_ext;
		w(8'h10, 8'h14);
		n = nb;
		cfg(8'h00, 8'h20, 8'h40, 8'h08, 8'h00);
		wack;
		pulse;
		repeat (20) @(posedge clk);
		xreq_n <= 1'h0;
		repeat (20) @(negedge clk);
		chk(xgnt_n, 8'h01);
		w(8'h10, 8'h1C);
		for (k = 0; k < 20 && xgnt_n !== 1'h0; k++) @(negedge clk);
		chk(xgnt_n, 8'h00);
		@(posedge clk);
		xreq_n <= 1'h1;
		w(8'h13, 8'hF0);
		wtc;
		chk(8'(nb - n), 8'h08);
		$display("abort with external master test done");
	endtask
	task automatic t_ext;
		w(8'h10, 8'h10);
		xreq_n <= 1'h0;
		for (k = 0; k < 20 && xgnt_n !== 1'h0; k++) @(negedge clk);
		chk(xgnt_n, 8'h00);
		cfg(8'h00, 8'h20, 8'h40, 8'h01, 8'h00);
		repeat (20) @(negedge clk);
		chk({xgnt_n, ack_n}, 8'h03);
		@(posedge clk);
		xreq_n <= 1'h1;
		wtc;
		chk(xgnt_n, 8'h01);
		$display("external master test done");
	endtask
	task automatic t_rst;
		cfg(8'h00, 8'h20, 8'h40, 8'h08, 8'h00);
		wack;
		@(posedge clk);
		rst_n <= 1'h0;
		#1 chk({xgnt_n, breq, ack_n}, 8'h0B);
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		rc(8'h02, 8'h00);
		rc(8'h04, 8'h00);
		$display("mid-run reset test done");
	endtask
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		t_reset;
		t_mm;
		t_abort;
		t_nmi_ext;
		t_wait(8'h00, 8'h00, 2'h2);
		// port 30 stands for an otherwise unused i/o address
		t_wait(8'h08, 8'h26, 2'h1);
		t_ext;
		t_rst;
		end_of_test;
	end
	initial begin
		repeat (6000) @(posedge clk);
		errors++;
		end_of_test;
	end
endmodule
bind dmaab_ctrl dmaab_checker #(.RESUME_CYCLES(RESUME_CYCLES)) i_chk (.i_clk, .i_rst_n,
	.i_addr, .i_wr_data, .i_wr_stb, .i_external_wait_ready, .i_ext_master_bus_request_n,
	.i_bus_grant, .o_bus_req, .o_bus, .o_transfer_acknowledge_n, .o_ext_master_bus_grant_n,
	.o_port_address_latch_strobe, .o_terminal_count);
